// >>> src/ocr_pkg.sv
// Shared constants for the capability reporting and packet request block.
// Assumes a single 250 MHz clock and a 32-bit AXI4-Lite register bus.
package ocr_pkg;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned T_SLOW_NS = 3000000;
   localparam int unsigned T_INTR_NS = 10000000;
   localparam int unsigned T_FAST_NS = 50000;
   localparam int unsigned SLOW_CYC = T_SLOW_NS / CLK_PERIOD_NS;
   localparam int unsigned INTR_CYC = T_INTR_NS / CLK_PERIOD_NS;
   localparam int unsigned FAST_CYC = T_FAST_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 22;

   localparam logic [1:0] CLS_SLOW = 2'h0;
   localparam logic [1:0] CLS_INTR = 2'h1;
   localparam logic [1:0] CLS_FAST = 2'h2;
   localparam logic [1:0] CLS_RSVD = 2'h3;
   localparam logic [1:0] PKT_12 = 2'h0;
   localparam logic [1:0] PKT_16 = 2'h1;
   localparam logic [7:0] OP_PACKET = 8'ha0;

   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_CAP = 8'h04;
   localparam logic [7:0] ADDR_REL_CMD = 8'h08;
   localparam logic [7:0] ADDR_REL_SVC = 8'h0c;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   localparam logic [7:0] ADDR_CTRL = 8'h14;

   localparam int unsigned CFG_CLS = 5;
   localparam int unsigned CFG_SIZE = 0;
   localparam int unsigned CAP_DMA = 8;
   localparam int unsigned CAP_LBA = 9;
   localparam int unsigned CAP_IORDY_FIX = 10;
   localparam int unsigned CAP_IORDY = 11;
   localparam int unsigned CAP_RSVD = 12;
   localparam int unsigned CAP_OVL = 13;
   localparam int unsigned CAP_QUEUE = 14;
   localparam int unsigned CAP_ILV = 15;
   localparam int unsigned CTRL_KEEP = 0;
   localparam int unsigned CTRL_OVL_EN = 1;
   localparam int unsigned ST_DRQ = 0;
   localparam int unsigned ST_INTRQ = 1;
   localparam int unsigned ST_OVL = 2;
   localparam int unsigned ST_AUTO = 3;
   localparam int unsigned ST_QUEUE = 4;
   localparam int unsigned ST_KEPT = 5;

   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [15:0] CAP_RST = 16'h0000;
   localparam logic [15:0] REL_RST = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      OCR_T_IDLE = 2'b00,
      OCR_T_WAIT = 2'b01,
      OCR_T_HOLD = 2'b11
   } ocr_tstate_t;
endpackage : ocr_pkg

// >>> src/ocr_drq_if.sv
// Signals between the register/command logic and the request timer.
// Assumes both ends run on aclk.
`timescale 1ns/1ps
interface ocr_drq_if;
   logic start;
   logic fw_ready;
   logic pkt_done;
   logic [1:0] cls;
   logic drq;
   logic intrq;
   logic busy;
   modport ctl (output start, fw_ready, pkt_done, cls,
                input drq, intrq, busy);
   modport tmr (input start, fw_ready, pkt_done, cls,
                output drq, intrq, busy);
endinterface : ocr_drq_if

// >>> src/ocr_drq_timer.sv
// Packet request timer: raises the data request after a packet command.
// Assumes start is only pulsed while busy is low.
`timescale 1ns/1ps
module ocr_drq_timer #(
   parameter int unsigned SLOW_CYC = ocr_pkg::SLOW_CYC,
   parameter int unsigned INTR_CYC = ocr_pkg::INTR_CYC,
   parameter int unsigned FAST_CYC = ocr_pkg::FAST_CYC
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Control side.
   ocr_drq_if.tmr dif
);
   import ocr_pkg::*;

   ocr_tstate_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d, lim;
   logic [1:0] cls_q, cls_d;
   logic drq_q, drq_d, intrq_q, intrq_d;

   // The reserved class falls back to the slow limit.
   always_comb begin
      case (cls_q)
         CLS_INTR: lim = CNT_W'(INTR_CYC);
         CLS_FAST: lim = CNT_W'(FAST_CYC);
         default: lim = CNT_W'(SLOW_CYC);
      endcase
   end

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      cls_d = cls_q;
      drq_d = drq_q;
      intrq_d = intrq_q;
      case (st_q)
         OCR_T_IDLE: begin
            if (dif.start) begin
               st_d = OCR_T_WAIT;
               cnt_d = '0;
               cls_d = dif.cls;
            end
         end
         OCR_T_WAIT: begin
            cnt_d = cnt_q + CNT_W'(1);
            // Drive the request no later than the class deadline.
            if (dif.fw_ready || cnt_q == lim - CNT_W'(1)) begin
               st_d = OCR_T_HOLD;
               drq_d = 1'b1;
               intrq_d = (cls_q == CLS_INTR);
            end
         end
         OCR_T_HOLD: begin
            if (dif.pkt_done) begin
               st_d = OCR_T_IDLE;
               drq_d = 1'b0;
               intrq_d = 1'b0;
            end
         end
         default: st_d = OCR_T_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= OCR_T_IDLE;
         cnt_q <= '0;
         cls_q <= CLS_SLOW;
         drq_q <= 1'b0;
         intrq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         cls_q <= cls_d;
         drq_q <= drq_d;
         intrq_q <= intrq_d;
      end
   end

   assign dif.drq = drq_q;
   assign dif.intrq = intrq_q;
   assign dif.busy = (st_q != OCR_T_IDLE);

   a_drq_deadline: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == OCR_T_WAIT |-> cnt_q < lim)
      else $error("request deadline exceeded");
   a_intr_with_drq: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(drq_q) && cls_q == CLS_INTR |-> intrq_q)
      else $error("interrupt class request without interrupt");
   a_no_intr_other: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(drq_q) && cls_q != CLS_INTR |-> !intrq_q)
      else $error("interrupt raised for non interrupt class");
endmodule : ocr_drq_timer

// >>> src/ocr_top.sv
// Identify capability words, packet request timing and overlap state.
// Assumes an AXI4-Lite master and a synchronous command port on aclk.
`timescale 1ns/1ps
module ocr_top #(
   parameter int unsigned SLOW_CYC = ocr_pkg::SLOW_CYC,
   parameter int unsigned INTR_CYC = ocr_pkg::INTR_CYC,
   parameter int unsigned FAST_CYC = ocr_pkg::FAST_CYC,
   // Arbitrary opcode values; set to the system's queued command codes.
   parameter logic [7:0] OP_RD_QUEUED = 8'hc0,
   parameter logic [7:0] OP_WR_QUEUED = 8'hc1,
   parameter logic [7:0] OP_RD_TAGGED = 8'hc2,
   parameter logic [7:0] OP_WR_TAGGED = 8'hc3,
   parameter bit HAS_REL_SEL = 1'b1,
   parameter bit HAS_PROXY = 1'b1
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write.
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read.
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Command port.
   input wire logic cmd_we,
   input wire logic [7:0] cmd_code,
   input wire logic fw_ready,
   input wire logic pkt_done,
   input wire logic svc_pend,
   input wire logic dma_pend,
   // Status outputs.
   output logic drq,
   output logic intrq,
   output logic service,
   output logic dma_ready,
   output logic overlap_active,
   output logic bus_release
);
   import ocr_pkg::*;

   localparam logic [2:0] R_CFG = 3'h0;
   localparam logic [2:0] R_CAP = 3'h1;
   localparam logic [2:0] R_REL_CMD = 3'h2;
   localparam logic [2:0] R_REL_SVC = 3'h3;
   localparam logic [2:0] R_STAT = 3'h4;
   localparam logic [2:0] R_CTRL = 3'h5;
   localparam logic [2:0] R_MISS = 3'h7;

   function automatic logic [2:0] dec(input logic [7:0] a);
      if (a == ADDR_CFG) dec = R_CFG;
      else if (a == ADDR_CAP) dec = R_CAP;
      else if (a == ADDR_REL_CMD) dec = R_REL_CMD;
      else if (a == ADDR_REL_SVC) dec = R_REL_SVC;
      else if (a == ADDR_STAT) dec = R_STAT;
      else if (a == ADDR_CTRL) dec = R_CTRL;
      else dec = R_MISS;
   endfunction : dec

   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      merge = old;
      if (s[0]) merge[7:0] = d[7:0];
      if (s[1]) merge[15:8] = d[15:8];
   endfunction : merge

   ocr_drq_if dif ();

   ocr_drq_timer #(
      .SLOW_CYC(SLOW_CYC),
      .INTR_CYC(INTR_CYC),
      .FAST_CYC(FAST_CYC)
   ) u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .dif(dif)
   );

   // Bus channel state.
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [7:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic do_wr;
   logic [2:0] wr_idx;

   // Register and command state.
   logic [15:0] cfg_q, cfg_d, cap_q, cap_d, rel_cmd_q, rel_cmd_d;
   logic [15:0] rel_svc_q, rel_svc_d, id0, id49;
   logic [1:0] ctrl_q, ctrl_d;
   logic auto_q, auto_d, queue_q, queue_d, kept_q, kept_d;
   logic svc_q, svc_d, dmar_q, dmar_d, rel_q, rel_d, ovl_q, ovl_d;
   logic ovl_ok, ovl_now, is_tag, is_queue;
   logic [5:0] stat;

   // Identify words as the host sees them.
   always_comb begin
      ovl_ok = cap_q[CAP_OVL] && HAS_REL_SEL && HAS_PROXY
         && rel_cmd_q != '0 && rel_svc_q != '0;
      id0 = cfg_q;
      id0[4:2] = 3'h0;
      id49 = cap_q;
      id49[CAP_LBA] = 1'b1;
      id49[CAP_RSVD] = 1'b0;
      id49[CAP_OVL] = ovl_ok;
      stat = {kept_q, queue_q, auto_q, ovl_q, dif.intrq, dif.drq};
   end

   assign wr_idx = dec(aw_addr_q);

   always_comb begin
      aw_have_d = aw_have_q;
      aw_addr_d = aw_addr_q;
      w_have_d = w_have_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (awvalid && awready_q) begin
         aw_have_d = 1'b1;
         aw_addr_d = awaddr;
      end
      if (wvalid && wready_q) begin
         w_have_d = 1'b1;
         w_data_d = wdata;
         w_strb_d = wstrb;
      end
      if (bvalid_q && bready) bvalid_d = 1'b0;
      do_wr = aw_have_q && w_have_q && !bvalid_q;
      if (do_wr) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (wr_idx == R_MISS) ? RESP_DECERR : RESP_OKAY;
      end
      awready_d = !aw_have_d;
      wready_d = !w_have_d;
      if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      if (arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = '0;
         case (dec(araddr))
            R_CFG: rdata_d[15:0] = id0;
            R_CAP: rdata_d[15:0] = id49;
            R_REL_CMD: rdata_d[15:0] = rel_cmd_q;
            R_REL_SVC: rdata_d[15:0] = rel_svc_q;
            R_STAT: rdata_d[5:0] = stat;
            R_CTRL: rdata_d[1:0] = ctrl_q;
            default: rresp_d = RESP_DECERR;
         endcase
      end
      // The read address is open whenever no read answer stands.
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else begin
         aw_have_q <= aw_have_d;
         aw_addr_q <= aw_addr_d;
         w_have_q <= w_have_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // Only the A0h write starts the request timer; no bit enables queuing.
   assign dif.start = cmd_we && cmd_code == OP_PACKET && !dif.busy;
   assign dif.fw_ready = fw_ready;
   assign dif.pkt_done = pkt_done;
   assign dif.cls = cfg_q[CFG_CLS +: 2];
   assign is_tag = cmd_we && (cmd_code == OP_RD_TAGGED
      || cmd_code == OP_WR_TAGGED);
   assign is_queue = is_tag || (cmd_we && (cmd_code == OP_RD_QUEUED
      || cmd_code == OP_WR_QUEUED));

   always_comb begin
      logic [15:0] nv;
      nv = merge(cfg_q, w_data_q, w_strb_q);
      cfg_d = cfg_q;
      cap_d = cap_q;
      rel_cmd_d = rel_cmd_q;
      rel_svc_d = rel_svc_q;
      ctrl_d = ctrl_q;
      auto_d = auto_q;
      queue_d = queue_q;
      kept_d = kept_q;
      if (do_wr) begin
         if (wr_idx == R_CFG) begin
            // Reserved codes leave the previous field in place.
            if (nv[CFG_CLS +: 2] == CLS_RSVD)
               nv[CFG_CLS +: 2] = cfg_q[CFG_CLS +: 2];
            if (nv[CFG_SIZE + 1])
               nv[CFG_SIZE +: 2] = cfg_q[CFG_SIZE +: 2];
            cfg_d = nv;
         end else if (wr_idx == R_CAP) begin
            cap_d = merge(cap_q, w_data_q, w_strb_q);
         end else if (wr_idx == R_REL_CMD) begin
            rel_cmd_d = merge(rel_cmd_q, w_data_q, w_strb_q);
         end else if (wr_idx == R_REL_SVC) begin
            rel_svc_d = merge(rel_svc_q, w_data_q, w_strb_q);
         end else if (wr_idx == R_CTRL && w_strb_q[0]) begin
            ctrl_d = w_data_q[1:0];
         end else if (wr_idx == R_STAT && w_strb_q[0]) begin
            if (w_data_q[ST_AUTO]) auto_d = 1'b0;
            if (w_data_q[ST_QUEUE]) queue_d = 1'b0;
            if (w_data_q[ST_KEPT]) kept_d = 1'b0;
         end
      end
      // Hardware events win over a clear in the same cycle.
      if (is_queue) queue_d = 1'b1;
      if (is_tag) auto_d = 1'b1;
      ovl_d = ctrl_d[CTRL_OVL_EN] || auto_d;
      svc_d = ovl_q && svc_pend;
      dmar_d = ovl_q && dma_pend;
      rel_d = pkt_done && ovl_q && !ctrl_q[CTRL_KEEP];
      if (pkt_done && ovl_q && ctrl_q[CTRL_KEEP]) kept_d = 1'b1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_q <= CFG_RST;
         cap_q <= CAP_RST;
         rel_cmd_q <= REL_RST;
         rel_svc_q <= REL_RST;
         ctrl_q <= 2'h0;
         auto_q <= 1'b0;
         queue_q <= 1'b0;
         kept_q <= 1'b0;
         ovl_q <= 1'b0;
         svc_q <= 1'b0;
         dmar_q <= 1'b0;
         rel_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         cap_q <= cap_d;
         rel_cmd_q <= rel_cmd_d;
         rel_svc_q <= rel_svc_d;
         ctrl_q <= ctrl_d;
         auto_q <= auto_d;
         queue_q <= queue_d;
         kept_q <= kept_d;
         ovl_q <= ovl_d;
         svc_q <= svc_d;
         dmar_q <= dmar_d;
         rel_q <= rel_d;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign drq = dif.drq;
   assign intrq = dif.intrq;
   assign service = svc_q;
   assign dma_ready = dmar_q;
   assign overlap_active = ovl_q;
   assign bus_release = rel_q;

   a_lba_one: assert property (@(posedge aclk) disable iff (!aresetn)
      id49[CAP_LBA] && !id49[CAP_RSVD])
      else $error("capability word lba or reserved bit wrong");
   a_resv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      id0[4:2] == 3'h0 && id0[CFG_CLS +: 2] != CLS_RSVD)
      else $error("configuration word reserved field nonzero");
   a_rel_valid: assert property (@(posedge aclk) disable iff (!aresetn)
      id49[CAP_OVL] |-> rel_cmd_q != '0 && rel_svc_q != '0)
      else $error("overlap reported without release times");
   a_ovl_gated: assert property (@(posedge aclk) disable iff (!aresetn)
      id49[CAP_OVL] |-> cap_q[CAP_OVL] && HAS_REL_SEL && HAS_PROXY)
      else $error("overlap reported without prerequisites");
   a_tag_overlap: assert property (@(posedge aclk) disable iff (!aresetn)
      is_tag |=> auto_q && overlap_active)
      else $error("tagged command did not enter overlap");
   a_queue_any: assert property (@(posedge aclk) disable iff (!aresetn)
      is_queue && !ovl_q |=> queue_q)
      else $error("queued command refused without overlap");
   a_svc_gated: assert property (@(posedge aclk) disable iff (!aresetn)
      (service || dma_ready) |-> $past(ovl_q))
      else $error("service status outside overlap");
   a_keep_bus: assert property (@(posedge aclk) disable iff (!aresetn)
      pkt_done && ovl_q && ctrl_q[CTRL_KEEP] |=> !bus_release && kept_q)
      else $error("bus released while keep selected");
   a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      do_wr |=> bvalid_q)
      else $error("write got no response");
endmodule : ocr_top

// >>> tb/ocr_host_model.sv
// Host adapter model: issues command codes and runs the packet handshake.
// Assumes the device command port and drq/intrq on aclk.
`timescale 1ns/1ps
module ocr_host_model (
   // Clock and trigger.
   input wire logic aclk,
   input wire logic go,
   input wire logic [7:0] op,
   input wire logic [3:0] dly,
   // Device side.
   input wire logic drq,
   input wire logic intrq,
   output logic cmd_we,
   output logic [7:0] cmd_code,
   output logic pkt_done,
   // Result of the last command.
   output logic busy,
   output logic irq_seen,
   output int lat
);
   import ocr_pkg::*;
   initial begin
      cmd_we = 1'b0;
      cmd_code = 8'h00;
      pkt_done = 1'b0;
      busy = 1'b0;
      irq_seen = 1'b0;
   end
   always begin
      @(posedge aclk);
      if (go) begin
         busy <= 1'b1;
         cmd_we <= 1'b1;
         cmd_code <= op;
         @(posedge aclk);
         cmd_we <= 1'b0;
         cmd_code <= ~op;
         // The count ends as the edge at which drq rose, from the A0 edge.
         lat = -1;
         while (op == OP_PACKET && !drq && lat < 100) begin
            @(posedge aclk);
            lat++;
         end
         irq_seen <= intrq;
         if (op == OP_PACKET) begin
            repeat (dly + 1) @(posedge aclk);
            pkt_done <= 1'b1;
            @(posedge aclk);
            pkt_done <= 1'b0;
            repeat (3) @(posedge aclk);
         end
         busy <= 1'b0;
      end
   end
endmodule : ocr_host_model

// >>> tb/tb_overlap_capability_reporting.sv
// Self-checking bench for the capability words and packet request timing.
// Assumes ocr_top with shortened request counts and the host model.
`timescale 1ns/1ps
module tb_overlap_capability_reporting;
   import ocr_pkg::*;
   localparam int unsigned LIM [3] = '{20, 40, 10};
   localparam logic [7:0] OPS [4] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3};
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, op = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, go = 1'b0;
   logic fw_ready = 1'b0, svc_pend = 1'b0, dma_pend = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf, dly = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, cmd_we, pkt_done;
   logic drq, intrq, service, dma_ready, overlap_active, bus_release;
   logic hm_busy, irq_seen;
   logic [1:0] bresp, rresp, m_ctl = 2'h0;
   logic [7:0] cmd_code;
   logic [15:0] m_cfg = 16'h0, m_cap = 16'h0, m_r71 = 16'h0;
   logic [15:0] m_r72 = 16'h0, seed = 16'he03f;
   int lat, fails = 0, samples_checked = 0, n_rel = 0;

   always #2 aclk = ~aclk;
   always @(posedge aclk) if (bus_release === 1'b1) n_rel <= n_rel + 1;

   ocr_top #(
      .SLOW_CYC(LIM[0]), .INTR_CYC(LIM[1]), .FAST_CYC(LIM[2]),
      .OP_RD_QUEUED(OPS[0]), .OP_WR_QUEUED(OPS[1]),
      .OP_RD_TAGGED(OPS[2]), .OP_WR_TAGGED(OPS[3])
   ) dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .cmd_we, .cmd_code,
      .fw_ready, .pkt_done, .svc_pend, .dma_pend, .drq, .intrq, .service,
      .dma_ready, .overlap_active, .bus_release
   );
   ocr_host_model hm (
      .aclk, .go, .op, .dly, .drq, .intrq, .cmd_we, .cmd_code, .pkt_done,
      .busy(hm_busy), .irq_seen, .lat
   );

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Expected read value from the bench's own copy of the registers.
   function automatic logic [31:0] expv(input logic [7:0] a);
      logic ovl;
      ovl = m_cap[CAP_OVL] && m_r71 != 16'h0 && m_r72 != 16'h0;
      case (a)
         ADDR_CFG: return {16'h0, m_cfg};
         ADDR_CAP: return {16'h0, m_cap[15:14], ovl, 1'b0, m_cap[11:10],
                           1'b1, m_cap[8:0]};
         ADDR_REL_CMD: return {16'h0, m_r71};
         ADDR_REL_SVC: return {16'h0, m_r72};
         ADDR_CTRL: return {30'h0, m_ctl};
         default: return 32'h0;
      endcase
   endfunction : expv

   task automatic mwr(input logic [7:0] a, input logic [31:0] d);
      case (a)
         ADDR_CFG: begin
            m_cfg[15:7] = d[15:7];
            if (d[6:5] != CLS_RSVD) m_cfg[6:5] = d[6:5];
            if (!d[1]) m_cfg[1:0] = d[1:0];
         end
         ADDR_CAP: m_cap = d[15:0];
         ADDR_REL_CMD: m_r71 = d[15:0];
         ADDR_REL_SVC: m_r72 = d[15:0];
         ADDR_CTRL: m_ctl = d[1:0];
         default: ;
      endcase
   endtask : mwr

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tmo(input int n);
      if (n >= 300) begin
         fails++;
         complete_run();
      end
   endtask : tmo

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      int n;
      logic ap, wp;
      ap = 1'b1;
      wp = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 300 && (ap || wp); n++) begin
         @(posedge aclk);
         if (ap && awready) awvalid <= 1'b0;
         if (wp && wready) wvalid <= 1'b0;
         ap = ap && !awready;
         wp = wp && !wready;
      end
      tmo(n);
      n = 0;
      do @(posedge aclk); while (!bvalid && ++n < 300);
      r = bresp;
      tmo(n);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do @(posedge aclk); while (!arready && ++n < 300);
      arvalid <= 1'b0;
      tmo(n);
      n = 0;
      do @(posedge aclk); while (!rvalid && ++n < 300);
      d = rdata;
      r = rresp;
      tmo(n);
   endtask : rd

   // Writes a register, then reads it back against the bench model.
   task automatic wc(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0] r;
      wr(a, d, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      mwr(a, d);
      rd(a, q, r);
      chk(q, expv(a));
   endtask : wc

   task automatic pkt(input logic [7:0] code);
      int n;
      op <= code;
      dly <= seed[3:0];
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      n = 0;
      do @(posedge aclk); while (hm_busy && ++n < 300);
      tmo(n);
   endtask : pkt

   initial begin
      logic [31:0] q;
      logic [1:0] r;
      int i;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 6; i++) begin
         rd(8'(i * 4), q, r);
         chk(q, expv(8'(i * 4)));
      end
      $display("Test reset done");
      wc(ADDR_REL_CMD, 32'h0);
      wc(ADDR_CAP, 32'hffff);
      wc(ADDR_REL_CMD, 32'h0005);
      wc(ADDR_REL_SVC, 32'h0007);
      wc(ADDR_CAP, 32'hffff);
      wc(ADDR_CAP, 32'h0);
      for (i = 0; i < 4; i++) wc(ADDR_CFG, 32'(i * 33));
      wc(ADDR_CFG, 32'hffff);
      for (i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wc(8'(i % 4 * 4), {~seed, seed});
      end
      wr(8'h18, 32'h1, r);
      chk({30'h0, r}, {30'h0, RESP_DECERR});
      rd(8'h20, q, r);
      chk({30'h0, r}, {30'h0, RESP_DECERR});
      chk(q, 32'h0);
      $display("Test registers done");
      for (i = 0; i < 3; i++) begin
         wc(ADDR_CFG, 32'(i * 32));
         pkt(OP_PACKET);
         chk(32'(lat <= LIM[i]), 32'h1);
         chk({31'h0, irq_seen}, {31'h0, i == 1});
      end
      fw_ready <= 1'b1;
      wc(ADDR_CFG, 32'h0);
      pkt(OP_PACKET);
      chk(32'(lat <= 2), 32'h1);
      $display("Test timing done");
      for (i = 0; i < 4; i++) begin
         wr(ADDR_STAT, 32'h38, r);
         pkt(OPS[i]);
         rd(ADDR_STAT, q, r);
         chk(q & 32'h18, (i > 1) ? 32'h18 : 32'h10);
         chk({31'h0, overlap_active}, {31'h0, i > 1});
      end
      svc_pend <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({30'h0, service, dma_ready}, 32'h2);
      svc_pend <= 1'b0;
      dma_pend <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({30'h0, service, dma_ready}, 32'h1);
      wr(ADDR_STAT, 32'h38, r);
      repeat (3) @(posedge aclk);
      chk({30'h0, service, dma_ready}, 32'h0);
      wc(ADDR_CTRL, 32'h2);
      i = n_rel;
      pkt(OP_PACKET);
      chk(32'(n_rel - i), 32'h1);
      wc(ADDR_CTRL, 32'h3);
      i = n_rel;
      pkt(OP_PACKET);
      // The host treats the bus as kept after three release times.
      repeat (3 * m_r71[3:0]) @(posedge aclk);
      rd(ADDR_STAT, q, r);
      chk(32'(n_rel - i), 32'h0);
      chk({31'h0, q[ST_KEPT]}, 32'h1);
      $display("Test overlap done");
      complete_run();
   end
endmodule : tb_overlap_capability_reporting
